// ==== ibd_acceptor.sv ====
// Acceptor three-wire handshake engine
`default_nettype none
module ibd_acceptor (
	input wire logic clk,
	input wire logic srst,
	input wire logic enable,
	input wire logic [7:0] bus_data,
	input wire logic dav,
	input wire logic atn,
	output logic nrfd_oe_n,
	output logic ndac_oe_n,
	ibd_byte_if.src rx
);
	// Whole state of the acceptor
	typedef struct packed {
		ibd_pkg::ibd_ah_t st;
		logic [7:0] data;
		logic vld;
		logic atn;
	} ibd_ah_reg_t;
	ibd_ah_reg_t cur_ff;
	ibd_ah_reg_t nxt_cur;

	// Step the handshake: hold NRFD until ready, release NDAC after taking
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.vld = 1'b0;
		case (cur_ff.st)
			ibd_pkg::AH_READY: begin
				if (dav && (enable || atn)) begin
					nxt_cur.st = ibd_pkg::AH_TAKE;
					nxt_cur.data = bus_data;
					nxt_cur.atn = atn;
				end
			end
			ibd_pkg::AH_TAKE: begin
				if (rx.ready) begin // Stall NDAC until consumer takes it
					nxt_cur.vld = 1'b1;
					nxt_cur.st = ibd_pkg::AH_WAIT_END;
				end
			end
			ibd_pkg::AH_WAIT_END: begin
				if (!dav) begin
					nxt_cur.st = ibd_pkg::AH_READY;
				end
			end
			default: nxt_cur.st = ibd_pkg::AH_READY;
		endcase
	end

	// Register the state; bus lines decode from it
	always_ff @(posedge clk) begin
		if (srst) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// Open-drain enables: low means pulling the line low; when idle (not listening,
	// no ATN) both float, since holding NDAC there would stall every other transfer
	assign nrfd_oe_n = (cur_ff.st == ibd_pkg::AH_READY) && !(dav && (enable || atn));
	assign ndac_oe_n = (cur_ff.st == ibd_pkg::AH_WAIT_END) ||
		((cur_ff.st == ibd_pkg::AH_READY) && !(enable || atn));
	assign rx.data = cur_ff.data;
	assign rx.valid = cur_ff.vld;
	assign rx.atn = cur_ff.atn;
endmodule
`default_nettype wire

// ==== ibd_byte_if.sv ====
// Interface carrying bytes between the handshake engines and the control logic
`default_nettype none
interface ibd_byte_if;
	logic [7:0] data; // Byte value
	logic valid; // Byte offered or taken
	logic ready; // Consumer can take a byte
	logic atn; // Byte was an interface message
	modport src(output data, output valid, output atn, input ready);
	modport snk(input data, input valid, input atn, output ready);
endinterface
`default_nettype wire

// ==== ibd_ctl_model.sv ====
// Bus controller and listen-always partner model
`default_nettype none
module ibd_ctl_model (
	input wire logic clk,
	input wire logic [7:0] dio_out,
	input wire logic dio_oe_n,
	input wire logic dav_oe_n,
	input wire logic nrfd_oe_n,
	input wire logic ndac_oe_n,
	output logic [7:0] dio_in,
	output logic dav_in,
	output logic nrfd_in,
	output logic ndac_in,
	output var logic atn,
	output var logic eoi_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] c_dio; // Our byte; inverted on release so stale data never looks valid
	logic c_dav, c_nrfd, c_ndac; // Our handshake drivers
	logic src_act; // We are sourcing
	logic [1:0] st; // Acceptor phase
	int wcnt; // Stall counter
	int slow; // Extra stall before accepting, set by the bench
	logic [7:0] rxq[$]; // Bytes taken from the device
	initial begin
		{c_dav, c_nrfd, c_ndac, src_act, atn, eoi_in} = '0;
		c_dio = 8'hff;
		st = 2'h0;
		slow = 0;
	end
	// Wired-OR of all parties on each handshake line; data lines carry the device byte while it drives, else ours
	assign dio_in = !dio_oe_n ? dio_out : c_dio;
	assign dav_in = c_dav | !dav_oe_n;
	assign nrfd_in = c_nrfd | !nrfd_oe_n;
	assign ndac_in = c_ndac | !ndac_oe_n;
	// Listen-always acceptor, idle while we source or hold ATN
	always @(posedge clk) begin
		if (src_act || atn) begin
			{c_nrfd, c_ndac} <= 2'h0;
			st <= 2'h0;
		end else if (st == 2'h0) begin
			c_ndac <= 1'b1;
			if (dav_in) begin // Byte offered
				rxq.push_back(dio_in);
				c_nrfd <= 1'b1;
				wcnt <= slow;
				st <= 2'h1;
			end
		end else if (st == 2'h1) begin
			if (wcnt > 0) wcnt <= wcnt - 1;
			else begin // Accept after the stall
				c_ndac <= 1'b0;
				st <= 2'h2;
			end
		end else if (!dav_in) begin // Rearm only after DAV drops
			c_ndac <= 1'b1;
			c_nrfd <= 1'b0;
			st <= 2'h0;
		end
	end
	// Source one byte, as a message when a is set
	task automatic send(input logic a, input logic [7:0] b);
		int n;
		@(posedge clk);
		src_act <= 1'b1;
		atn <= a;
		c_dio <= b;
		n = 0;
		repeat (2) @(posedge clk);
		while (nrfd_in !== 1'b0 && n < 500) begin // Wait for ready
			@(posedge clk);
			n++;
		end
		c_dav <= 1'b1;
		@(posedge clk);
		while (ndac_in !== 1'b0 && n < 1000) begin // Wait for accept
			@(posedge clk);
			n++;
		end
		c_dav <= 1'b0;
		c_dio <= ~b;
		@(posedge clk);
		src_act <= 1'b0;
	endtask
	// Let the addressed talker run
	task automatic release_atn();
		@(posedge clk);
		atn <= 1'b0;
	endtask
	// Parallel poll: ATN with EOI for four cycles
	task automatic ppoll();
		@(posedge clk);
		atn <= 1'b1;
		eoi_in <= 1'b1;
		repeat (4) @(posedge clk);
		eoi_in <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== ibd_pkg.sv ====
// Package of constants and types for the instrument bus device interface
`default_nettype none
package ibd_pkg;
	// Interface message codes carried on the data lines while ATN is asserted
	localparam logic [7:0] MSG_GTL = 8'h01; // Go to local, addressed
	localparam logic [7:0] MSG_SDC = 8'h04; // Selected device clear
	localparam logic [7:0] MSG_GET = 8'h08; // Group execute trigger, addressed
	localparam logic [7:0] MSG_TCT = 8'h09; // Take control, always ignored
	localparam logic [7:0] MSG_LLO = 8'h11; // Local lockout, universal
	localparam logic [7:0] MSG_DCL = 8'h14; // Device clear, universal
	localparam logic [7:0] MSG_SPE = 8'h18; // Serial poll enable
	localparam logic [7:0] MSG_SPD = 8'h19; // Serial poll disable
	localparam logic [7:0] MSG_UNL = 8'h3f; // Unlisten
	localparam logic [7:0] MSG_UNT = 8'h5f; // Untalk
	localparam logic [2:0] GRP_LISTEN = 3'h1; // Listen address group, bits 7:5
	localparam logic [2:0] GRP_TALK = 3'h2; // Talk address group, bits 7:5
	localparam logic [4:0] ADDR_FACTORY = 5'h14; // Factory address 20
	localparam int SRQ_BIT = 6; // Bit 7 in one-based numbering
	// Source handshake settle time before DAV, in ns, and its cycle count
	localparam int T_SETTLE_NS = 20;
	localparam int CLK_NS = 10;
	localparam int SETTLE_CYC = (T_SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] SETTLE_CNT = 4'(SETTLE_CYC);
	// Source handshake states
	typedef enum logic [1:0] {
		SH_IDLE = 2'b00,
		SH_SETTLE = 2'b01,
		SH_WAIT_NFD = 2'b10,
		SH_WAIT_DAC = 2'b11
	} ibd_sh_t;
	// Acceptor handshake states
	typedef enum logic [1:0] {
		AH_READY = 2'b00,
		AH_TAKE = 2'b01,
		AH_WAIT_END = 2'b10
	} ibd_ah_t;
endpackage
`default_nettype wire

// ==== ibd_source.sv ====
// Source three-wire handshake engine
`default_nettype none
module ibd_source (
	input wire logic clk,
	input wire logic srst,
	input wire logic abort,
	input wire logic nrfd,
	input wire logic ndac,
	output logic [7:0] bus_data,
	output logic dav_oe_n,
	ibd_byte_if.snk tx
);
	// Whole state of the source
	typedef struct packed {
		ibd_pkg::ibd_sh_t st;
		logic [7:0] data;
		logic [3:0] cnt;
	} ibd_sh_reg_t;
	ibd_sh_reg_t cur_ff;
	ibd_sh_reg_t nxt_cur;

	// Settle data, assert DAV once all ready, drop it once all accepted
	always_comb begin
		nxt_cur = cur_ff;
		case (cur_ff.st)
			ibd_pkg::SH_IDLE: begin
				if (tx.valid) begin
					nxt_cur.data = tx.data;
					nxt_cur.cnt = ibd_pkg::SETTLE_CNT;
					nxt_cur.st = ibd_pkg::SH_SETTLE;
				end
			end
			ibd_pkg::SH_SETTLE: begin
				if (cur_ff.cnt > 4'h1) begin
					nxt_cur.cnt = cur_ff.cnt - 4'h1;
				end else if (!nrfd) begin
					nxt_cur.st = ibd_pkg::SH_WAIT_NFD;
				end
			end
			ibd_pkg::SH_WAIT_NFD: begin
				if (!ndac) begin
					nxt_cur.st = ibd_pkg::SH_WAIT_DAC;
				end
			end
			ibd_pkg::SH_WAIT_DAC: begin
				nxt_cur.st = ibd_pkg::SH_IDLE;
			end
			default: nxt_cur.st = ibd_pkg::SH_IDLE;
		endcase
		if (abort) begin
			nxt_cur.st = ibd_pkg::SH_IDLE;
		end
	end

	// Register the state
	always_ff @(posedge clk) begin
		if (srst) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign tx.ready = (cur_ff.st == ibd_pkg::SH_IDLE);
	assign bus_data = cur_ff.data;
	assign dav_oe_n = (cur_ff.st != ibd_pkg::SH_WAIT_NFD); // DAV low only here
endmodule
`default_nettype wire

// ==== ibd_top.sv ====
// Device-side bus interface functions: addressing, remote/local, poll, trigger
//
// Overview of operation
// - Full three-wire source handshake on talked bytes
// - Full acceptor handshake on every received byte
// - Talker, serial poll status, talk-only mode
// - Listen only when addressed; no listen-only
// - Never respond to parallel poll
// - Never take control; ignore pass control
// - Same output format addressed or talk-only
// - Send current or next measurement per wait
// - Leave talk-only via addressable switch plus reset
// - Accept unbounded command bytes when listening
// - SRQ at measurement end if enabled and waiting
// - Remote ignores panel except reset/local key
// - Lockout disables local key until go-to-local
// - Go-to-local returns local and clears lockout
// - Device clear resets and restarts measurement
// - Trigger while remote restarts measurement
// - Unaddressed group trigger ignored; addressed trigger goes remote
// - Entering remote locks switches, applies defaults unless settings programmed
// - Status byte bit 7 means service requested
// - Interface clear drops addressing, and the indicator unless talk-only
// - Address from five switches, factory 20
// - Mode switch: addressable or talk-only
// - Addressed and remote indicators
`default_nettype none
module ibd_top #(
	parameter int RESULT_BYTES = 4 // Bytes per measurement result
) (
	input wire logic clk,
	input wire logic srst,
	// Bus data lines: input, output, enable (low means driving)
	input wire logic [7:0] dio_in,
	output logic [7:0] dio_out,
	output logic dio_oe_n,
	// Handshake and management lines: inputs true means asserted, enables low means driving
	input wire logic dav_in,
	output logic dav_oe_n,
	input wire logic nrfd_in,
	output logic nrfd_oe_n,
	input wire logic ndac_in,
	output logic ndac_oe_n,
	input wire logic atn,
	input wire logic ifc,
	input wire logic ren,
	input wire logic eoi_in,
	output logic srq_oe_n,
	// Rear panel switches
	input wire logic talk_only_sw,
	input wire logic address_switch_msb,
	input wire logic [2:0] address_switch_mid,
	input wire logic address_switch_lsb,
	// Front panel
	input wire logic reset_key,
	input wire logic wait_mode,
	input wire logic srq_enable,
	input wire logic settings_programmed,
	// Measurement engine
	input wire logic meas_done,
	input wire logic [8*RESULT_BYTES-1:0] meas_result,
	output logic meas_restart,
	output logic apply_defaults,
	output logic panel_enable,
	// Command byte stream to the command parser
	output logic [7:0] cmd_byte,
	output logic cmd_valid,
	// Indicators
	output logic addressed_indicator,
	output logic remote_indicator
);
	localparam int IW = $clog2(RESULT_BYTES + 1);

	// Whole state of the control logic
	typedef struct packed {
		logic talk_only;
		logic tad;
		logic lad;
		logic spms;
		logic rem;
		logic llo;
		logic rsv;
		logic held;
		logic [8*RESULT_BYTES-1:0] result;
		logic [IW-1:0] idx;
		logic want;
		logic restart;
		logic defaults;
		logic [7:0] cmd;
		logic cmd_vld;
		logic reset_key_d;
	} ibd_ctl_t;
	ibd_ctl_t cur_ff;
	ibd_ctl_t nxt_cur;

	ibd_byte_if rx_if();
	ibd_byte_if tx_if();

	logic [4:0] my_addr;
	logic [7:0] src_data;
	logic src_dav_oe_n;
	logic acc_nrfd_oe_n;
	logic acc_ndac_oe_n;
	logic tx_go;
	logic [7:0] tx_byte;
	logic key_press;
	logic talk_en; // Talker may drive data and DAV

	// Five switches form the bus address, top switch is the top bit
	assign my_addr = {address_switch_msb, address_switch_mid, address_switch_lsb};

	// Match an address byte of a given group against our switches
	function automatic logic addr_hit(input logic [7:0] b, input logic [2:0] grp,
		input logic [4:0] a);
		addr_hit = (b[6:5] == grp[1:0]) && (b[4:0] == a);
	endfunction

	// Acceptor listens only when addressed; messages are always taken
	ibd_acceptor u_acc (
		.clk(clk),
		.srst(srst),
		.enable(cur_ff.lad && !cur_ff.talk_only),
		.bus_data(dio_in),
		.dav(dav_in && dav_oe_n), // Own DAV is never a byte for us
		.atn(atn),
		.nrfd_oe_n(acc_nrfd_oe_n),
		.ndac_oe_n(acc_ndac_oe_n),
		.rx(rx_if.src)
	);
	assign rx_if.ready = 1'b1; // Command bytes never stall: any count accepted

	// Source paces each talked byte
	ibd_source u_src (
		.clk(clk),
		.srst(srst),
		.abort(!talk_en),
		.nrfd(nrfd_in),
		.ndac(ndac_in),
		.bus_data(src_data),
		.dav_oe_n(src_dav_oe_n),
		.tx(tx_if.snk)
	);
	assign tx_if.data = tx_byte;
	assign tx_if.valid = tx_go;
	assign tx_if.atn = 1'b0;

	// Talk only when the controller lets go of ATN
	assign key_press = reset_key && !cur_ff.reset_key_d;
	// Losing talk rights drops the byte in flight at once
	assign talk_en = (cur_ff.tad || cur_ff.talk_only) && !atn && !ifc;
	always_comb begin
		tx_go = 1'b0;
		tx_byte = cur_ff.result[8*RESULT_BYTES-1 -: 8];
		if (cur_ff.spms) begin
			tx_byte = 8'h00;
			tx_byte[ibd_pkg::SRQ_BIT] = cur_ff.rsv;
		end
		if (!atn && !ifc && (cur_ff.tad || cur_ff.talk_only)) begin
			tx_go = cur_ff.spms || (cur_ff.idx != '0); // Same byte path both modes
		end
	end

	// Control state: message decode, remote/local, talker data and service request
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.restart = 1'b0;
		nxt_cur.defaults = 1'b0;
		nxt_cur.cmd_vld = 1'b0;
		nxt_cur.reset_key_d = reset_key;
		// Talked byte taken by the source: move on to the next one
		if (tx_go && tx_if.ready && !cur_ff.spms) begin
			nxt_cur.result = {cur_ff.result[8*RESULT_BYTES-9:0], 8'h00};
			nxt_cur.idx = cur_ff.idx - IW'(1);
			if (cur_ff.idx == IW'(1) && cur_ff.held) begin
				nxt_cur.held = 1'b0; // Held result sent, start next one
				nxt_cur.restart = 1'b1;
			end
		end
		if (tx_go && tx_if.ready && cur_ff.spms) begin
			nxt_cur.rsv = 1'b0; // Polled: request is answered
		end
		// Measurement finished: load result unless one is held or mid-send
		if (meas_done && !cur_ff.held && (cur_ff.idx == '0)) begin
			nxt_cur.want = cur_ff.tad || cur_ff.talk_only;
			if (wait_mode || cur_ff.tad || cur_ff.talk_only) begin
				nxt_cur.result = meas_result;
				nxt_cur.idx = IW'(RESULT_BYTES);
				nxt_cur.held = wait_mode && !cur_ff.talk_only;
			end
			if (srq_enable && wait_mode && !cur_ff.talk_only) begin
				nxt_cur.rsv = 1'b1;
			end
		end
		// Received bytes
		if (rx_if.valid && !rx_if.atn) begin
			nxt_cur.cmd = rx_if.data;
			nxt_cur.cmd_vld = 1'b1;
		end
		if (rx_if.valid && rx_if.atn && !cur_ff.talk_only) begin
			case (rx_if.data[6:0])
				ibd_pkg::MSG_LLO[6:0]: nxt_cur.llo = 1'b1;
				ibd_pkg::MSG_DCL[6:0]: nxt_cur.restart = 1'b1;
				ibd_pkg::MSG_SPE[6:0]: nxt_cur.spms = 1'b1;
				ibd_pkg::MSG_SPD[6:0]: nxt_cur.spms = 1'b0;
				ibd_pkg::MSG_UNL[6:0]: nxt_cur.lad = 1'b0;
				ibd_pkg::MSG_UNT[6:0]: nxt_cur.tad = 1'b0;
				ibd_pkg::MSG_TCT[6:0]: nxt_cur = nxt_cur; // Never take control
				default: begin
					// Address groups; own talk address also untalks nobody else
					if (addr_hit(rx_if.data, ibd_pkg::GRP_LISTEN, my_addr)) begin
						nxt_cur.lad = 1'b1;
						if (ren && !cur_ff.rem) begin
							nxt_cur.rem = 1'b1;
							nxt_cur.defaults = !settings_programmed;
							nxt_cur.restart = 1'b1;
						end
					end else if (addr_hit(rx_if.data, ibd_pkg::GRP_TALK, my_addr)) begin
						nxt_cur.tad = 1'b1;
					end else if (rx_if.data[6:5] == ibd_pkg::GRP_TALK[1:0]) begin
						nxt_cur.tad = 1'b0; // Other talker addressed
					end
					// Addressed commands need us listening
					if (cur_ff.lad && rx_if.data[6:0] == ibd_pkg::MSG_GTL[6:0]) begin
						nxt_cur.rem = 1'b0;
						nxt_cur.llo = 1'b0;
					end
					if (cur_ff.lad && rx_if.data[6:0] == ibd_pkg::MSG_SDC[6:0]) begin
						nxt_cur.restart = 1'b1;
					end
					if (cur_ff.lad && rx_if.data[6:0] == ibd_pkg::MSG_GET[6:0]) begin
						nxt_cur.restart = 1'b1;
						if (!cur_ff.rem) begin
							nxt_cur.rem = 1'b1; // Addressed trigger forces remote
							nxt_cur.defaults = !settings_programmed;
						end
					end
				end
			endcase
		end
		// Front panel reset/local key
		if (key_press) begin
			if (!talk_only_sw) begin
				nxt_cur.talk_only = 1'b0; // Switch alone never exits
			end
			if (!(cur_ff.rem && cur_ff.llo)) begin // Locked out while in lockout
				nxt_cur.rem = 1'b0;
				nxt_cur.restart = 1'b1;
			end
		end
		// Mode switch enters talk-only any time
		if (talk_only_sw) begin
			nxt_cur.talk_only = 1'b1;
		end
		// Remote enable line dropped: back to local, lockout gone
		if (!ren) begin
			nxt_cur.rem = 1'b0;
			nxt_cur.llo = 1'b0;
		end
		// Interface clear ends all addressing and any talk in progress
		if (ifc) begin
			nxt_cur.tad = 1'b0;
			nxt_cur.lad = 1'b0;
			nxt_cur.spms = 1'b0;
		end
	end

	// Register the control state; reset puts the device in local, unaddressed
	always_ff @(posedge clk) begin
		if (srst) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// Output flops so every port comes straight from a register
	always_ff @(posedge clk) begin
		if (srst) begin
			dio_out <= 8'h00;
			dio_oe_n <= 1'b1;
			dav_oe_n <= 1'b1;
			nrfd_oe_n <= 1'b1;
			ndac_oe_n <= 1'b1;
			srq_oe_n <= 1'b1;
			meas_restart <= 1'b0;
			apply_defaults <= 1'b0;
			panel_enable <= 1'b1;
			cmd_byte <= 8'h00;
			cmd_valid <= 1'b0;
			addressed_indicator <= 1'b0;
			remote_indicator <= 1'b0;
		end else begin
			dio_out <= src_data;
			// Data lines driven only while talking with ATN off; no parallel poll drive
			dio_oe_n <= !talk_en;
			dav_oe_n <= src_dav_oe_n || !talk_en; // Data and DAV let go together
			nrfd_oe_n <= acc_nrfd_oe_n;
			ndac_oe_n <= acc_ndac_oe_n;
			srq_oe_n <= !cur_ff.rsv;
			meas_restart <= cur_ff.restart;
			apply_defaults <= cur_ff.defaults;
			panel_enable <= !cur_ff.rem;
			cmd_byte <= cur_ff.cmd;
			cmd_valid <= cur_ff.cmd_vld;
			addressed_indicator <= cur_ff.tad || cur_ff.lad || cur_ff.talk_only;
			remote_indicator <= cur_ff.rem;
		end
	end
endmodule
`default_nettype wire

// ==== ibd_top_bench.sv ====
// Self-checking bench for the instrument bus device port
`default_nettype none
module ibd_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic a; // Sent under ATN
		logic [7:0] b; // Byte sent
		logic adr; // Addressed light after
		logic rem; // Remote light after
		logic [1:0] rs; // Restart: 1 yes, 0 no, 2 either
	} ibd_row_t;
	logic clk, srst, ifc, ren, talk_only_sw, reset_key, wait_mode, srq_enable, meas_done;
	logic [4:0] addr_sw; // All five address switches
	logic [31:0] meas_result;
	logic [7:0] dio_in, dio_out, cmd_byte, last_cmd;
	logic dio_oe_n, dav_in, dav_oe_n, nrfd_in, nrfd_oe_n, ndac_in, ndac_oe_n, atn, eoi_in;
	logic srq_oe_n, meas_restart, panel_enable, cmd_valid, addressed_indicator, remote_indicator;
	logic apply_defaults, settings_prog;
	int bad_count, n_tests, rs_cnt, rs0, df_cnt;
	// Message and data sequence, address 20, remote enable held
	ibd_row_t rows [0:14] = '{'{1'b1, 8'h14, 1'b0, 1'b0, 2'h1}, '{1'b1, 8'h34, 1'b1, 1'b1, 2'h2},
		'{1'b0, 8'h41, 1'b1, 1'b1, 2'h0}, '{1'b0, 8'h42, 1'b1, 1'b1, 2'h0},
		'{1'b1, 8'h08, 1'b1, 1'b1, 2'h1}, '{1'b1, 8'h04, 1'b1, 1'b1, 2'h1},
		'{1'b1, 8'h09, 1'b1, 1'b1, 2'h0}, '{1'b1, 8'h11, 1'b1, 1'b1, 2'h0},
		'{1'b1, 8'h01, 1'b1, 1'b0, 2'h0}, '{1'b1, 8'h08, 1'b1, 1'b1, 2'h1},
		'{1'b1, 8'h01, 1'b1, 1'b0, 2'h0}, '{1'b1, 8'h3f, 1'b0, 1'b0, 2'h0},
		'{1'b1, 8'h08, 1'b0, 1'b0, 2'h0}, '{1'b1, 8'h34, 1'b1, 1'b1, 2'h2},
		'{1'b1, 8'h3f, 1'b0, 1'b1, 2'h0}};
	ibd_top #(.RESULT_BYTES(4)) u_dut (
		.clk(clk), .srst(srst), .dio_in(dio_in), .dio_out(dio_out), .dio_oe_n(dio_oe_n),
		.dav_in(dav_in), .dav_oe_n(dav_oe_n), .nrfd_in(nrfd_in), .nrfd_oe_n(nrfd_oe_n),
		.ndac_in(ndac_in), .ndac_oe_n(ndac_oe_n), .atn(atn), .ifc(ifc), .ren(ren),
		.eoi_in(eoi_in), .srq_oe_n(srq_oe_n), .talk_only_sw(talk_only_sw),
		.address_switch_msb(addr_sw[4]), .address_switch_mid(addr_sw[3:1]),
		.address_switch_lsb(addr_sw[0]), .reset_key(reset_key), .wait_mode(wait_mode),
		.srq_enable(srq_enable), .settings_programmed(settings_prog), .meas_done(meas_done),
		.meas_result(meas_result), .meas_restart(meas_restart),
		.apply_defaults(apply_defaults), .panel_enable(panel_enable), .cmd_byte(cmd_byte),
		.cmd_valid(cmd_valid),
		.addressed_indicator(addressed_indicator), .remote_indicator(remote_indicator));
	ibd_ctl_model u_ctl (
		.clk(clk), .dio_out(dio_out), .dio_oe_n(dio_oe_n), .dav_oe_n(dav_oe_n),
		.nrfd_oe_n(nrfd_oe_n), .ndac_oe_n(ndac_oe_n), .dio_in(dio_in), .dav_in(dav_in),
		.nrfd_in(nrfd_in), .ndac_in(ndac_in), .atn(atn), .eoi_in(eoi_in));
	// Free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Count restart and default pulses, keep the last command byte
	always @(posedge clk) begin
		if (meas_restart === 1'b1)
			rs_cnt <= rs_cnt + 1;
		if (cmd_valid === 1'b1)
			last_cmd <= cmd_byte;
		if (apply_defaults === 1'b1)
			df_cnt <= df_cnt + 1;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, seen);
			bad_count++;
		end
	endtask
	task automatic finish_test();
		$display("TB: %0d mismatches in %0d checks", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Send one byte and let the three-edge answer land
	task automatic put(input logic a, input logic [7:0] b);
		u_ctl.send(a, b);
		repeat (6) @(posedge clk);
	endtask
	// One press of the front-panel key
	task automatic press_key();
		reset_key <= 1'b1;
		repeat (3) @(posedge clk);
		reset_key <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	// Wait, bounded, until the listener holds n bytes
	task automatic wait_rx(input int n);
		int k;
		k = 0;
		while (u_ctl.rxq.size() < n && k < 3000) begin
			@(posedge clk);
			k++;
		end
	endtask
	// Four result bytes, most significant first
	task automatic chk_result(input logic [31:0] v);
		for (int k = 0; k < 4; k++)
			check("result byte", u_ctl.rxq[k], v[31-8*k -: 8]); // Order and format
	endtask
	// Hang guard, well past the expected run
	initial begin
		repeat (30000) @(posedge clk);
		bad_count++;
		finish_test();
	end
	initial begin
		{srst, ren} = 2'h3;
		{ifc, talk_only_sw, reset_key, wait_mode, srq_enable, meas_done, settings_prog} = '0;
		{bad_count, n_tests, rs_cnt, df_cnt} = '0;
		addr_sw = ibd_pkg::ADDR_FACTORY;
		meas_result = 32'h3132_3334;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge clk);
		check("addressed", addressed_indicator, 1'b0); // Idle after reset
		check("srq", srq_oe_n, 1'b1); // Idle after reset
		for (int i = 0; i < 15; i++) begin
			rs0 = rs_cnt;
			put(rows[i].a, rows[i].b);
			check("addressed", addressed_indicator, rows[i].adr); // Addressing
			check("remote", remote_indicator, rows[i].rem); // Remote state
			check("panel", panel_enable, !rows[i].rem); // Panel lock
			if (!rows[i].a)
				check("command", last_cmd, rows[i].b); // Listener data
			if (rows[i].rs != 2'h2)
				check("restart", rs_cnt != rs0, rows[i].rs[0]); // Clear, trigger
		end
		press_key();
		check("remote", remote_indicator, 1'b0); // Local key works
		put(1'b1, 8'h34);
		put(1'b1, 8'h11);
		press_key();
		check("remote", remote_indicator, 1'b1); // Key locked out
		put(1'b1, 8'h01);
		check("remote", remote_indicator, 1'b0); // Controller unlocks
		put(1'b1, 8'h3f);
		srq_enable <= 1'b1;
		wait_mode <= 1'b1;
		@(posedge clk);
		meas_done <= 1'b1;
		@(posedge clk);
		meas_done <= 1'b0;
		repeat (4) @(posedge clk);
		check("srq", srq_oe_n, 1'b0); // End of measurement
		u_ctl.rxq.delete();
		put(1'b1, 8'h18);
		put(1'b1, 8'h54);
		u_ctl.release_atn();
		wait_rx(1);
		check("status srq bit", u_ctl.rxq[0][ibd_pkg::SRQ_BIT], 1'b1); // Poll byte
		put(1'b1, 8'h19);
		put(1'b1, 8'h5f);
		check("srq", srq_oe_n, 1'b1); // Cleared by poll
		u_ctl.rxq.delete();
		rs0 = rs_cnt;
		put(1'b1, 8'h54);
		u_ctl.release_atn();
		wait_rx(4);
		repeat (6) @(posedge clk);
		chk_result(32'h3132_3334); // Held result talked
		check("restart", rs_cnt != rs0, 1'b1); // New measurement after output
		put(1'b1, 8'h5f);
		wait_mode <= 1'b0;
		u_ctl.slow <= 3;
		u_ctl.release_atn();
		u_ctl.rxq.delete();
		talk_only_sw <= 1'b1;
		repeat (4) @(posedge clk);
		check("addressed", addressed_indicator, 1'b1); // Talk-only light
		meas_result <= 32'h3938_3736;
		meas_done <= 1'b1;
		@(posedge clk);
		meas_done <= 1'b0;
		wait_rx(4);
		chk_result(32'h3938_3736); // Unaddressed output, slow listener
		talk_only_sw <= 1'b0;
		repeat (4) @(posedge clk);
		check("addressed", addressed_indicator, 1'b1); // Switch alone keeps mode
		press_key();
		check("addressed", addressed_indicator, 1'b0); // Switch plus key exits
		u_ctl.ppoll();
		check("data drive", dio_oe_n, 1'b1); // No poll answer
		addr_sw <= 5'h03;
		put(1'b1, 8'h34);
		check("addressed", addressed_indicator, 1'b0); // Old address ignored
		check("defaults", df_cnt, 4); // One per remote entry
		settings_prog <= 1'b1;
		put(1'b1, 8'h23);
		check("addressed", addressed_indicator, 1'b1); // Switch address used
		check("defaults", df_cnt, 4); // Programmed settings kept
		ifc <= 1'b1;
		repeat (3) @(posedge clk);
		ifc <= 1'b0;
		repeat (3) @(posedge clk);
		check("addressed", addressed_indicator, 1'b0); // Abort unaddresses
		finish_test();
	end
endmodule
`default_nettype wire

// ==== ibd_top_checker.sv ====
// Assertion checker bound to the instrument bus device top
`default_nettype none
module ibd_top_checker #(
	parameter int RESULT_BYTES = 4 // Result width, as in the top
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] dio_out,
	input wire logic dio_oe_n,
	input wire logic dav_in,
	input wire logic dav_oe_n,
	input wire logic nrfd_in,
	input wire logic nrfd_oe_n,
	input wire logic ndac_in,
	input wire logic atn,
	input wire logic ifc,
	input wire logic eoi_in,
	input wire logic srq_oe_n,
	input wire logic talk_only_sw,
	input wire logic srq_enable,
	input wire logic wait_mode,
	input wire logic [8*RESULT_BYTES-1:0] meas_result,
	input wire logic cmd_valid,
	input wire logic panel_enable,
	input wire logic addressed_indicator,
	input wire logic remote_indicator
);
	timeunit 1ns;
	timeprecision 100ps;
	// One clock domain, so clock and reset are given once
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	// DAV may only go out once every acceptor was ready
	chk_dav_ready: assert property ($fell(dav_oe_n) |-> !$past(nrfd_in))
		else $error("DAV asserted while NRFD was up");
	// DAV stays until all acceptors took the byte, unless aborted
	chk_dav_hold: assert property (!dav_oe_n && ndac_in && !atn && !ifc |=> !dav_oe_n)
		else $error("DAV dropped before NDAC released");
	// Data lines driven and steady while DAV is out
	chk_dav_data: assert property (!dav_oe_n |-> !dio_oe_n && ($fell(dav_oe_n) || $stable(dio_out)))
		else $error("Data lines moved under DAV");
	// A command byte only follows a data byte handshaken three edges earlier
	chk_cmd_dav: assert property (cmd_valid |-> $past(dav_in, 3) && !$past(atn, 3))
		else $error("Command byte without a handshaken data byte");
	// NRFD held while the source still shows DAV
	chk_nrfd_hold: assert property (!nrfd_oe_n && dav_in && !ifc |=> !nrfd_oe_n)
		else $error("NRFD released under DAV");
	// Service request only with enable and wait both set
	chk_srq_cause: assert property ($fell(srq_oe_n) |-> srq_enable && wait_mode)
		else $error("SRQ without enable and wait");
	// Parallel poll never answered on the data lines
	chk_par_poll: assert property ((atn && eoi_in) [*3] |-> dio_oe_n)
		else $error("Data lines driven in parallel poll");
	// Panel locked while remote has settled
	chk_panel_lock: assert property (remote_indicator && $past(remote_indicator) |-> !panel_enable)
		else $error("Panel enabled while remote");
	// Interface clear drops addressing
	chk_ifc_clear: assert property ((ifc && !talk_only_sw) [*2] |=> !addressed_indicator)
		else $error("Still addressed after interface clear");
	// Main traffic kinds seen at least once
	cover property ($fell(dav_oe_n));
	cover property (cmd_valid);
	cover property ($fell(srq_oe_n));
endmodule
bind ibd_top ibd_top_checker #(.RESULT_BYTES(RESULT_BYTES)) u_chk (
	.clk(clk), .srst(srst), .dio_out(dio_out), .dio_oe_n(dio_oe_n),
	.dav_in(dav_in), .dav_oe_n(dav_oe_n), .nrfd_in(nrfd_in), .nrfd_oe_n(nrfd_oe_n),
	.ndac_in(ndac_in), .atn(atn), .ifc(ifc), .eoi_in(eoi_in), .srq_oe_n(srq_oe_n),
	.talk_only_sw(talk_only_sw), .srq_enable(srq_enable), .wait_mode(wait_mode),
	.meas_result(meas_result), .cmd_valid(cmd_valid), .panel_enable(panel_enable),
	.addressed_indicator(addressed_indicator), .remote_indicator(remote_indicator)
);
`default_nettype wire
